// file: src/uecr_map.vh
// Offsets, field positions and reset values of the extended control registers
`ifndef UECR_MAP_VH
`define UECR_MAP_VH
`define UECR_IDX_SPECIAL_ONE 8'h01
`define UECR_IDX_SPECIAL_TWO 8'h02
`define UECR_IDX_SPECIAL_THREE 8'h03
`define UECR_IDX_SPECIAL_FOUR 8'h04
`define UECR_IDX_NINTH_BIT_MODE 8'h0d
`define UECR_IDX_MODEM_MASK 8'h0e
`define UECR_IDX_FIFO_READBACK 8'h0f
`define UECR_IDX_GOOD_DATA 8'h10
`define UECR_IDX_TEST_STATUS 8'h11
`define UECR_IDX_CHANNEL_INDEX 8'h12
`define UECR_IDX_CLOCK_ALT 8'h13
`define UECR_IDX_ACCESS_STEER 8'h14
`define UECR_RESET_BYTE 8'h00
`define UECR_NMR_WRITE_MASK 8'h3f
`define UECR_MDM_WRITE_MASK 8'h0f
`define UECR_STEER_WRITE_MASK 8'h01
`define UECR_CHANNEL_NUMBER 8'h00
`define UECR_NMR_ENABLE 0
`define UECR_NMR_CHAR_LSB 2
`define UECR_IER_MODEM 3
`define UECR_IER_SPECIAL 5
`define UECR_LSR_OVERRUN 1
`define UECR_LSR_FIFO_ERR 7
`define UECR_MASK_CTS 0
`define UECR_MASK_DSR 1
`define UECR_MASK_RI 2
`define UECR_MASK_DCD 3
`define UECR_CKA_RX_INV 0
`define UECR_CKA_TX_INV 1
`define UECR_CKA_DTR_INV 2
`define UECR_STEER_BIT 0
`define UECR_ISR_NONE 6'h01
`define UECR_ISR_RX_DATA 6'h04
`define UECR_ISR_RX_TIMEOUT 6'h0c
`define UECR_ISR_TX_EMPTY 6'h02
`define UECR_MODE_NORMAL 2'h0
`define UECR_MODE_LOCAL_BUS 2'h1
`define UECR_MODE_GENERIC 2'h2
`define UECR_NUM_CHARS 4
`define UECR_PIN_IDLE 4'h0
`endif

// file: src/uecr_char_match.v
// Matcher comparing a received nine-bit character against four special characters
`timescale 1ns/1ps
`default_nettype none
`include "uecr_map.vh"
module uecr_char_match #(
	parameter CHAR_WIDTH = 9
) (
	input wire [CHAR_WIDTH-1:0] rxChar,
	input wire [8*`UECR_NUM_CHARS-1:0] lowBytes,
	input wire [`UECR_NUM_CHARS-1:0] ninthBits,
	output wire hit
);
	genvar i;
	wire [`UECR_NUM_CHARS-1:0] each;
	// One comparator per special character; ninth bit from its own mode bit
	generate
		for (i = 0; i < `UECR_NUM_CHARS; i = i + 1) begin : gCmp
			assign each[i] = (rxChar == {ninthBits[i], lowBytes[8*i +: 8]});
		end
	endgenerate
	assign hit = |each;
endmodule // uecr_char_match
`default_nettype wire

// file: src/uecr_regs.v
// Extended indexed control registers: nine-bit matching, modem masks, clock inversion
`timescale 1ns/1ps
`default_nettype none
`include "uecr_map.vh"
// Behaviour
// - Nine-bit and enhanced mode plus special interrupt enable turn on address matching.
// - Match characters use special registers one to four plus ninth-bit mode bits 2-5.
// - A match raises a level 5 interrupt when the character enters the FIFO.
// - Nine-bit framing active only while ninth-bit mode bit 0 is set.
// - Ninth-bit mode bits 6 and 7 always read zero.
// - Hardware reset clears the modem mask, leaving every modem event unmasked.
// - Mask bit 0 clear lets CTS change interrupt and wake; set blocks both.
// - Mask bit 1 clear lets DSR change interrupt and wake; set blocks both.
// - Mask bit 2 clear lets trailing ring edge interrupt and wake; set blocks both.
// - Mask bit 3 clear lets carrier-detect change interrupt and wake; set blocks both.
// - FIFO readback is read-only and returns the last FIFO control write.
// - Good-data bit set only for benign interrupt status and clear error, overrun bits.
// - Channel index is read-only and returns zero.
// - Clock alteration clears on hardware reset and survives software reset.
// - Clock alteration bit 0 inverts the receiver clock.
// - Clock alteration bit 1 inverts the transmitter clock.
// - Clock alteration bit 2 inverts the DTR pin, also when it carries a clock.
// - In local bus mode steering bit 0 picks local bus (0) or config registers (1).
// - In generic mode steering overlays config registers; bit 0 clears on exit.
module uecr_regs (
	input wire ref_clk,
	input wire rst,
	input wire softReset,
	input wire [7:0] regIndex,
	input wire [7:0] writeData,
	input wire writeStrobe,
	output reg [7:0] readData,
	input wire [7:0] fifoControlData,
	input wire fifoControlWrite,
	input wire [7:0] interruptEnable,
	input wire enhancedMode,
	input wire [5:0] interruptStatus,
	input wire [7:0] lineStatus,
	input wire [8:0] rxChar,
	input wire rxCharPush,
	input wire matchClear,
	output reg matchInterrupt,
	output wire ninthBitFraming,
	input wire ctsPin,
	input wire dsrPin,
	input wire riPin,
	input wire dcdPin,
	output reg modemInterrupt,
	output reg wakeUp,
	input wire [7:0] testStatus,
	input wire rxClockRaw,
	input wire txClockRaw,
	input wire dtrRaw,
	output wire rxClock,
	output wire txClock,
	output wire dtrPin,
	input wire [1:0] busMode,
	output wire configSelect,
	output wire localBusSelect
);
	reg [7:0] specialOne;
	reg [7:0] specialTwo;
	reg [7:0] specialThree;
	reg [7:0] specialFour;
	reg [7:0] ninthBitMode;
	reg [7:0] modemEventMask;
	reg [7:0] fifoControlReadback;
	reg [7:0] clockAlteration;
	reg [7:0] accessSteering;
	reg [1:0] prevMode;
	reg [3:0] modemSync1;
	reg [3:0] modemSync2;
	reg [3:0] modemLast;
	reg goodData;
	reg [7:0] next_readData;
	wire matchHit;
	wire matchEnable;
	wire [3:0] modemEvent;
	wire [3:0] modemRaw;
	wire leaveGeneric;

	// Masked write helper keeps reserved bits at zero
	function [7:0] maskWrite;
		input [7:0] value;
		input [7:0] mask;
		begin
			maskWrite = value & mask;
		end
	endfunction

	// Index decode helper, used by every register write; the read mux decodes with a case
	function hitIndex;
		input [7:0] index;
		input [7:0] target;
		begin
			hitIndex = (index == target);
		end
	endfunction

	// Change on one synchronised modem line, blocked by its mask bit
	function lineChange;
		input now;
		input last;
		input masked;
		begin
			lineChange = (now ^ last) & ~masked;
		end
	endfunction

	// Interrupt status codes under which received data still counts as good
	function benignStatus;
		input [5:0] status;
		begin
			benignStatus = (status == `UECR_ISR_NONE)
				| (status == `UECR_ISR_RX_DATA)
				| (status == `UECR_ISR_RX_TIMEOUT)
				| (status == `UECR_ISR_TX_EMPTY);
		end
	endfunction

	assign ninthBitFraming = ninthBitMode[`UECR_NMR_ENABLE];
	// Matching needs nine-bit, enhanced and the special enable together
	assign matchEnable = ninthBitFraming & enhancedMode
		& interruptEnable[`UECR_IER_SPECIAL];

	uecr_char_match #(
		.CHAR_WIDTH(9)
	) uMatch (
		.rxChar(rxChar),
		.lowBytes({specialFour, specialThree, specialTwo, specialOne}),
		.ninthBits(ninthBitMode[`UECR_NMR_CHAR_LSB +: `UECR_NUM_CHARS]),
		.hit(matchHit)
	);

	// Special characters; only hard reset clears them
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			specialOne <= `UECR_RESET_BYTE;
			specialTwo <= `UECR_RESET_BYTE;
			specialThree <= `UECR_RESET_BYTE;
			specialFour <= `UECR_RESET_BYTE;
		end else if (writeStrobe && !softReset) begin
			if (hitIndex(regIndex, `UECR_IDX_SPECIAL_ONE)) begin
				specialOne <= writeData;
			end
			if (hitIndex(regIndex, `UECR_IDX_SPECIAL_TWO)) begin
				specialTwo <= writeData;
			end
			if (hitIndex(regIndex, `UECR_IDX_SPECIAL_THREE)) begin
				specialThree <= writeData;
			end
			if (hitIndex(regIndex, `UECR_IDX_SPECIAL_FOUR)) begin
				specialFour <= writeData;
			end
		end
	end

	// Ninth-bit mode; soft reset drops framing back to eight bits
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ninthBitMode <= `UECR_RESET_BYTE;
		end else if (softReset) begin
			ninthBitMode <= `UECR_RESET_BYTE;
		end else if (writeStrobe && hitIndex(regIndex, `UECR_IDX_NINTH_BIT_MODE)) begin
			ninthBitMode <= maskWrite(writeData, `UECR_NMR_WRITE_MASK);
		end
	end

	// Modem mask; upper bits dropped even if software ignores its duty
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			modemEventMask <= `UECR_RESET_BYTE;
		end else if (softReset) begin
			modemEventMask <= `UECR_RESET_BYTE;
		end else if (writeStrobe && hitIndex(regIndex, `UECR_IDX_MODEM_MASK)) begin
			modemEventMask <= maskWrite(writeData, `UECR_MDM_WRITE_MASK);
		end
	end

	// Clock alteration; kept off the soft reset path so a channel reset
	// does not glitch a clock that the user has just inverted
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clockAlteration <= `UECR_RESET_BYTE;
		end else if (writeStrobe && !softReset
			&& hitIndex(regIndex, `UECR_IDX_CLOCK_ALT)) begin
			clockAlteration <= writeData;
		end
	end

	// Shadow of the write-only FIFO control register; the host cannot read
	// the real one, so this copy is its only view of the FIFO setup
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fifoControlReadback <= `UECR_RESET_BYTE;
		end else if (fifoControlWrite) begin
			fifoControlReadback <= fifoControlData;
		end
	end

	// Bus mode one cycle back, to spot the exit from generic mode
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prevMode <= `UECR_MODE_NORMAL;
		end else begin
			prevMode <= busMode;
		end
	end

	// High for the one cycle in which generic mode has just been left
	assign leaveGeneric = (prevMode == `UECR_MODE_GENERIC)
		&& (busMode != `UECR_MODE_GENERIC);

	// Steering register; bit 0 drops when generic mode is left, and the
	// exit wins over a write in the same cycle so no stale overlay survives
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			accessSteering <= `UECR_RESET_BYTE;
		end else if (leaveGeneric) begin
			accessSteering[`UECR_STEER_BIT] <= 1'b0;
		end else if (writeStrobe && hitIndex(regIndex, `UECR_IDX_ACCESS_STEER)) begin
			accessSteering <= maskWrite(writeData, `UECR_STEER_WRITE_MASK);
		end
	end

	// Local bus mode: bit low selects local bus, high selects configuration
	assign localBusSelect = (busMode == `UECR_MODE_LOCAL_BUS)
		& ~accessSteering[`UECR_STEER_BIT];
	// Generic mode overlays configuration registers; normal mode ignores the bit
	assign configSelect = ((busMode == `UECR_MODE_LOCAL_BUS)
		| (busMode == `UECR_MODE_GENERIC)) & accessSteering[`UECR_STEER_BIT];

	// Match flag; a hit in the clearing cycle wins over the clear
	// Losing any of the three enables drops a pending request at once
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			matchInterrupt <= 1'b0;
		end else if (rxCharPush && matchEnable && matchHit) begin
			matchInterrupt <= 1'b1;
		end else if (matchClear || !matchEnable) begin
			matchInterrupt <= 1'b0;
		end
	end

	// Modem pins come from outside, so two flops before edge detection
	assign modemRaw = {dcdPin, riPin, dsrPin, ctsPin};
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			modemSync1 <= `UECR_PIN_IDLE;
			modemSync2 <= `UECR_PIN_IDLE;
		end else begin
			modemSync1 <= modemRaw;
			modemSync2 <= modemSync1;
		end
	end

	// Line history one cycle behind the synchroniser output
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			modemLast <= `UECR_PIN_IDLE;
		end else begin
			modemLast <= modemSync2;
		end
	end

	// Changes on CTS, DSR, DCD; ring counts only its trailing (falling) edge
	assign modemEvent[`UECR_MASK_CTS] = lineChange(modemSync2[`UECR_MASK_CTS],
		modemLast[`UECR_MASK_CTS], modemEventMask[`UECR_MASK_CTS]);
	assign modemEvent[`UECR_MASK_DSR] = lineChange(modemSync2[`UECR_MASK_DSR],
		modemLast[`UECR_MASK_DSR], modemEventMask[`UECR_MASK_DSR]);
	// A falling ring line is a change whose previous level was high
	assign modemEvent[`UECR_MASK_RI] = lineChange(modemSync2[`UECR_MASK_RI],
		modemLast[`UECR_MASK_RI], modemEventMask[`UECR_MASK_RI])
		& modemLast[`UECR_MASK_RI];
	assign modemEvent[`UECR_MASK_DCD] = lineChange(modemSync2[`UECR_MASK_DCD],
		modemLast[`UECR_MASK_DCD], modemEventMask[`UECR_MASK_DCD]);

	// Level 4 request pulse, gated by the modem interrupt enable
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			modemInterrupt <= 1'b0;
		end else begin
			modemInterrupt <= (|modemEvent) & interruptEnable[`UECR_IER_MODEM];
		end
	end

	// Wake pulse ignores the interrupt enable: a sleeping channel must
	// still wake on a line change with its interrupts switched off
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wakeUp <= 1'b0;
		end else begin
			wakeUp <= |modemEvent;
		end
	end

	// Good data: benign interrupt status and no errors pending
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			goodData <= 1'b0;
		end else begin
			goodData <= benignStatus(interruptStatus)
				& ~lineStatus[`UECR_LSR_FIFO_ERR]
				& ~lineStatus[`UECR_LSR_OVERRUN];
		end
	end

	// Clock and pin inversions; plain XOR so no extra delay cell choice
	assign rxClock = rxClockRaw ^ clockAlteration[`UECR_CKA_RX_INV];
	assign txClock = txClockRaw ^ clockAlteration[`UECR_CKA_TX_INV];
	assign dtrPin = dtrRaw ^ clockAlteration[`UECR_CKA_DTR_INV];

	// Read mux; unmapped indexes read zero, so a driver probing for
	// registers that this channel lacks sees no stray bits
	always @* begin
		next_readData = `UECR_RESET_BYTE;
		case (regIndex)
			`UECR_IDX_SPECIAL_ONE: next_readData = specialOne;
			`UECR_IDX_SPECIAL_TWO: next_readData = specialTwo;
			`UECR_IDX_SPECIAL_THREE: next_readData = specialThree;
			`UECR_IDX_SPECIAL_FOUR: next_readData = specialFour;
			`UECR_IDX_NINTH_BIT_MODE: next_readData = ninthBitMode;
			`UECR_IDX_MODEM_MASK: next_readData = modemEventMask;
			`UECR_IDX_FIFO_READBACK: next_readData = fifoControlReadback;
			`UECR_IDX_GOOD_DATA: next_readData = {7'h00, goodData};
			`UECR_IDX_TEST_STATUS: next_readData = testStatus;
			`UECR_IDX_CHANNEL_INDEX: next_readData = `UECR_CHANNEL_NUMBER;
			`UECR_IDX_CLOCK_ALT: next_readData = clockAlteration;
			`UECR_IDX_ACCESS_STEER: next_readData = accessSteering;
			default: next_readData = `UECR_RESET_BYTE;
		endcase
	end

	// Registered read data, one cycle after the index
	// The extra cycle buys a clean flop output on the host data bus
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			readData <= `UECR_RESET_BYTE;
		end else begin
			readData <= next_readData;
		end
	end
endmodule // uecr_regs
`default_nettype wire

// file: dv/uecr_host_model.sv
// Host model issuing indexed register reads and writes
`timescale 1ns/1ps
`default_nettype none
module uecr_host_model (
	input wire logic ref_clk,
	output logic [7:0] regIndex,
	output logic [7:0] writeData,
	output logic writeStrobe,
	input wire logic [7:0] readData
);
	// Idle: no strobe
	initial begin
		regIndex = 8'h00;
		writeData = 8'h00;
		writeStrobe = 1'b0;
	end
	// Reserved bits of the modem mask and steering registers go out as zeros; data scrambled once released
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge ref_clk);
		#1 regIndex = idx;
		writeData = (idx == 8'h0e) ? d & 8'h0f : (idx == 8'h14) ? d & 8'h01 : d;
		writeStrobe = 1'b1;
		@(posedge ref_clk);
		#1 writeStrobe = 1'b0;
		writeData = ~writeData;
	endtask
	// Read data lags the index by one edge
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		@(posedge ref_clk);
		#1 regIndex = idx;
		@(posedge ref_clk);
		#1 d = readData;
	endtask
endmodule // uecr_host_model
`default_nettype wire

// file: dv/uecr_regs_asserts.sv
// Port checks for the extended control registers
`timescale 1ns/1ps
`default_nettype none
module uecr_regs_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic softReset,
	input wire logic [7:0] regIndex,
	input wire logic [7:0] writeData,
	input wire logic writeStrobe,
	input wire logic [7:0] readData,
	input wire logic [7:0] fifoControlData,
	input wire logic fifoControlWrite,
	input wire logic [5:0] interruptStatus,
	input wire logic [7:0] lineStatus,
	input wire logic ctsPin,
	input wire logic wakeUp,
	input wire logic rxClockRaw,
	input wire logic txClockRaw,
	input wire logic dtrRaw,
	input wire logic rxClock,
	input wire logic txClock,
	input wire logic dtrPin
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic ctsMasked;
	logic [7:0] lastFcr;
	wire goodNow;
	// Shadows of the cts mask and last fifo control write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctsMasked <= 1'b0;
			lastFcr <= 8'h00;
		end else begin
			if (softReset) ctsMasked <= 1'b0;
			else if (writeStrobe && regIndex == 8'h0e) ctsMasked <= writeData[0];
			if (fifoControlWrite) lastFcr <= fifoControlData;
		end
	end
	// Benign status, no error summary, no overrun
	assign goodNow = (interruptStatus == 6'h01 || interruptStatus == 6'h04 ||
		interruptStatus == 6'h0c || interruptStatus == 6'h02) && !lineStatus[7] && !lineStatus[1];
	sequence s_wr_alt;
		writeStrobe && regIndex == 8'h13;
	endsequence
	sequence s_cts_event;
		$changed(ctsPin) && !ctsMasked;
	endsequence
	property p_rx_inv;
		s_wr_alt |=> rxClock == (rxClockRaw ^ $past(writeData[0]));
	endproperty
	property p_tx_inv;
		s_wr_alt |=> txClock == (txClockRaw ^ $past(writeData[1]));
	endproperty
	property p_dtr_inv;
		s_wr_alt |=> dtrPin == (dtrRaw ^ $past(writeData[2]));
	endproperty
	property p_chan_zero;
		regIndex == 8'h12 |=> readData == 8'h00;
	endproperty
	property p_nmr_rsvd;
		regIndex == 8'h0d |=> readData[7:6] == 2'b00;
	endproperty
	property p_good;
		regIndex == 8'h10 |=> readData == {7'h00, $past(goodNow, 2)};
	endproperty
	property p_fifo_rb;
		regIndex == 8'h0f |=> readData == $past(lastFcr);
	endproperty
	// Two sync flops plus detect: wake within four edges
	property p_cts_wake;
		s_cts_event |-> ##[1:4] wakeUp;
	endproperty
	a_rx_inv: assert property (p_rx_inv) else $error("rx clock sense wrong");
	a_tx_inv: assert property (p_tx_inv) else $error("tx clock sense wrong");
	a_dtr_inv: assert property (p_dtr_inv) else $error("dtr sense wrong");
	a_chan_zero: assert property (p_chan_zero) else $error("channel index not zero");
	a_nmr_rsvd: assert property (p_nmr_rsvd) else $error("ninth-bit top bits set");
	a_good: assert property (p_good) else $error("good data status wrong");
	a_fifo_rb: assert property (p_fifo_rb) else $error("fifo readback wrong");
	a_cts_wake: assert property (p_cts_wake) else $error("cts change gave no wake");
endmodule // uecr_regs_asserts
bind uecr_regs uecr_regs_asserts chk_u (.ref_clk, .rst, .softReset, .regIndex, .writeData,
	.writeStrobe, .readData, .fifoControlData, .fifoControlWrite, .interruptStatus, .lineStatus,
	.ctsPin, .wakeUp, .rxClockRaw, .txClockRaw, .dtrRaw, .rxClock, .txClock, .dtrPin);
`default_nettype wire

// file: dv/uecr_regs_tb.sv
// Self-checking bench for the extended control registers
`timescale 1ns/1ps
`default_nettype none
module uecr_regs_tb;
	logic ref_clk, rst, softReset, fifoControlWrite, enhancedMode, rxCharPush, matchClear;
	logic rxClockRaw, txClockRaw, dtrRaw, writeStrobe, matchInterrupt, ninthBitFraming;
	logic modemInterrupt, wakeUp, rxClock, txClock, dtrPin, configSelect, localBusSelect;
	logic [7:0] fifoControlData, interruptEnable, lineStatus, regIndex, writeData, readData, rd;
	logic [5:0] interruptStatus;
	logic [8:0] rxChar;
	logic [3:0] pins;
	logic [1:0] busMode;
	int failCount = 0;
	int checkCount = 0;
	uecr_regs dut_u (.ref_clk, .rst, .softReset, .regIndex, .writeData, .writeStrobe, .readData,
		.fifoControlData, .fifoControlWrite, .interruptEnable, .enhancedMode, .interruptStatus,
		.lineStatus, .rxChar, .rxCharPush, .matchClear, .matchInterrupt, .ninthBitFraming,
		.ctsPin(pins[0]), .dsrPin(pins[1]), .riPin(pins[2]), .dcdPin(pins[3]), .modemInterrupt,
		.wakeUp, .testStatus(8'h5a), .rxClockRaw, .txClockRaw, .dtrRaw, .rxClock, .txClock,
		.dtrPin, .busMode, .configSelect, .localBusSelect);
	uecr_host_model host_u (.ref_clk, .regIndex, .writeData, .writeStrobe, .readData);
	task automatic chk(input string what, input logic [7:0] want, input logic [7:0] got);
		checkCount++;
		if (got !== want) begin
			failCount++;
			$display("Error %s expected %h seen %h", what, want, got);
		end
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] want, input string what);
		host_u.rd(idx, rd);
		chk(what, want, rd);
	endtask
	task automatic pulse(ref logic s);
		@(posedge ref_clk);
		#1 s = 1'b1;
		@(posedge ref_clk);
		#1 s = 1'b0;
	endtask
	task automatic push(input logic [8:0] c);
		rxChar = c;
		pulse(rxCharPush);
	endtask
	// Counts modem and wake pulses over eight edges; unknowns never count
	task automatic pulses(output int n, output int w);
		n = 0;
		w = 0;
		repeat (8) begin
			@(posedge ref_clk);
			#1;
			if (modemInterrupt === 1'b1) n++;
			if (wakeUp === 1'b1) w++;
		end
	endtask
	task automatic finishTest;
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic tRegs;
		rc(8'h0e, 8'h00, "mask");
		rc(8'h13, 8'h00, "clkalt");
		host_u.wr(8'h0d, 8'hff);
		rc(8'h0d, 8'h3f, "ninth");
		host_u.wr(8'h12, 8'hff);
		rc(8'h12, 8'h00, "chan");
		fifoControlData = 8'hc7;
		pulse(fifoControlWrite);
		host_u.wr(8'h0f, 8'h00);
		rc(8'h0f, 8'hc7, "fifo rb");
	endtask
	task automatic tClock;
		host_u.wr(8'h13, 8'h07);
		{rxClockRaw, txClockRaw, dtrRaw} = 3'b101;
		#1 chk("inv", 8'h02, {5'h0, rxClock, txClock, dtrPin});
		pulse(softReset);
		rc(8'h13, 8'h07, "clk soft");
		pulse(rst);
		rc(8'h13, 8'h00, "clk hard");
		#1 chk("no inv", 8'h05, {5'h0, rxClock, txClock, dtrPin});
	endtask
	task automatic tGood;
		logic [5:0] st [5] = '{6'h01, 6'h04, 6'h0c, 6'h02, 6'h06};
		for (int i = 0; i < 5; i++) begin
			interruptStatus = st[i];
			rc(8'h10, {7'h0, i < 4}, "good");
		end
		interruptStatus = 6'h01;
		lineStatus = 8'h80;
		rc(8'h10, 8'h00, "good err");
		lineStatus = 8'h02;
		rc(8'h10, 8'h00, "good ovr");
	endtask
	task automatic tModem(input logic [7:0] interrupt_enable, input logic [7:0] mask);
		int n, w;
		logic [7:0] wantIrq, wantWake;
		interruptEnable = interrupt_enable;
		host_u.wr(8'h0e, mask);
		for (int i = 0; i < 4; i++) begin
			wantWake = {7'h0, !mask[i]};
			wantIrq = {7'h0, !mask[i] && interrupt_enable[3]};
			pins[i] = 1'b1;
			pulses(n, w);
			chk("modem rise", (i == 2) ? 8'h00 : wantIrq, n[7:0]);
			chk("wake rise", (i == 2) ? 8'h00 : wantWake, w[7:0]);
			pins[i] = 1'b0;
			pulses(n, w);
			chk("modem fall", wantIrq, n[7:0]);
			chk("wake fall", wantWake, w[7:0]);
		end
	endtask
	task automatic tMatch;
		enhancedMode = 1'b1;
		interruptEnable = 8'h20;
		for (int i = 0; i < 4; i++) begin
			host_u.wr(8'h01 + i[7:0], 8'h30 + i[7:0]);
			host_u.wr(8'h0d, 8'h01 | (8'h04 << i));
			push({1'b0, 8'h30 + i[7:0]});
			chk("no match", 8'h00, {7'h0, matchInterrupt});
			push({1'b1, 8'h30 + i[7:0]});
			chk("match", 8'h01, {7'h0, matchInterrupt});
			pulse(matchClear);
		end
		host_u.wr(8'h0d, 8'h3c);
		push(9'h133);
		chk("framing off", 8'h00, {6'h0, ninthBitFraming, matchInterrupt});
		host_u.wr(8'h0d, 8'h3d);
		enhancedMode = 1'b0;
		push(9'h133);
		chk("no enhanced", 8'h00, {7'h0, matchInterrupt});
		enhancedMode = 1'b1;
		interruptEnable = 8'h00;
		push(9'h133);
		chk("no enable", 8'h00, {7'h0, matchInterrupt});
		interruptEnable = 8'h20;
		push(9'h133);
		chk("match four", 8'h01, {7'h0, matchInterrupt});
	endtask
	task automatic tSteer;
		busMode = 2'h1;
		host_u.wr(8'h14, 8'h01);
		chk("steer cfg", 8'h02, {6'h0, configSelect, localBusSelect});
		host_u.wr(8'h14, 8'h00);
		chk("steer bus", 8'h01, {6'h0, configSelect, localBusSelect});
		busMode = 2'h2;
		host_u.wr(8'h14, 8'h01);
		chk("steer overlay", 8'h02, {6'h0, configSelect, localBusSelect});
		busMode = 2'h0;
		repeat (2) @(posedge ref_clk);
		rc(8'h14, 8'h00, "steer exit");
		host_u.wr(8'h14, 8'h01);
		chk("steer normal", 8'h00, {6'h0, configSelect, localBusSelect});
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Run needs about 375 cycles; 10000 cycles, over 25 times that, means a hang
	initial begin
		#200000;
		failCount++;
		finishTest;
	end
	initial begin
		rst = 1'b1;
		{softReset, fifoControlWrite, enhancedMode, rxCharPush, matchClear, rxClockRaw} = '0;
		{txClockRaw, dtrRaw, fifoControlData, interruptEnable, lineStatus, rxChar, pins} = '0;
		interruptStatus = 6'h01;
		busMode = 2'h0;
		repeat (5) @(posedge ref_clk);
		#1 rst = 1'b0;
		tRegs;
		tClock;
		tGood;
		tModem(8'h08, 8'h00);
		tModem(8'h00, 8'h00);
		tModem(8'h08, 8'h0f);
		tModem(8'h08, 8'h05);
		tMatch;
		tSteer;
		finishTest;
	end
endmodule // uecr_regs_tb
`default_nettype wire
